// File: hdl/kes_pkg.sv
// Constants, types and field arithmetic for the binary key equation solver.
// Assumes an upstream syndrome source and a downstream locator evaluation stage.
//
// Overview of operation
// RULE_01 - On go, copy the syndrome coefficients into the V polynomial registers.
// RULE_02 - Compute locator L(x) and its degree by modified Berlekamp-Massey iteration.
// RULE_03 - Each codeword starts with L(x) = 1 and V(x) = S(x).
// RULE_04 - Auxiliary aL(x), aV(x) start equal to L(x), V(x).
// RULE_05 - Both pairs keep S*L = V and S*aL = aV modulo x^2t.
// RULE_06 - Every second discrepancy is zero for binary codes; those steps are skipped.
// RULE_07 - Iteration j examines V coefficient j; j starts at zero with S1.
// RULE_08 - A nonzero discrepancy modifies L(x) and raises its degree when required.
// RULE_09 - Two-way mode makes two coefficients of each of L, aL, V, aV per cycle.
// RULE_10 - When finished, raise the result pending flag for the next stage.
// RULE_11 - Results held while pending; downstream takes them and clears the flag.
// RULE_12 - Control keeps an iteration index and a coefficient group index.
// RULE_13 - Locator degree starts at zero per codeword and only grows as needed.
// RULE_14 - Locator degree unequal to corrected error count marks codeword uncorrectable.
// RULE_15 - Branch inputs change only at the end of each full polynomial iteration.
// RULE_16 - Two-way latency scales as capability times actual errors plus overhead.
// RULE_17 - Fully parallel setting updates all coefficients at once, parallelism 2t.
// RULE_18 - Upstream gives go as one-cycle pulse, syndrome stable, never while pending.

package kes_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int M      = 8;
    localparam int T_CAP  = 4;
    localparam int N2     = 2 * T_CAP;
    // 2 gives the two-way solver; N2 gives the fully parallel one
    localparam int LANES  = 2;
    localparam int GROUPS = N2 / LANES;

    localparam logic [7:0] GF_POLY    = 8'h1D;
    localparam logic [7:0] ELEM_ONE   = 8'h01;
    localparam logic [7:0] ELEM_ZERO  = 8'h00;
    localparam logic [3:0] DEG_RESET  = 4'h0;
    localparam logic [3:0] J_RESET    = 4'h0;
    localparam logic [3:0] J_STEP     = 4'h2;
    localparam logic [3:0] J_LAST     = 4'h8;
    localparam logic [1:0] GRP_TOP    = 2'(GROUPS - 1);
    localparam logic [1:0] GRP_BOTTOM = 2'h0;

    // ************************************************************
    // types
    // ************************************************************
    typedef logic [M-1:0] kes_elem_t;
    typedef kes_elem_t [N2-1:0] kes_poly_t;

    typedef struct packed {
        kes_elem_t [T_CAP:0] loc;
        logic [3:0]          deg;
    } kes_result_t;

    // ************************************************************
    // field multiply
    // ************************************************************
    function automatic kes_elem_t kes_gf_mul(input kes_elem_t a, input kes_elem_t b);
        kes_elem_t p;
        kes_elem_t s;
        p = ELEM_ZERO;
        s = a;
        for (int k = 0; k < M; k++) begin
            if (b[k]) begin
                p = p ^ s;
            end
            s = s[M-1] ? ({s[M-2:0], 1'b0} ^ GF_POLY) : {s[M-2:0], 1'b0};
        end
        return p;
    endfunction : kes_gf_mul

endpackage : kes_pkg

// File: hdl/kes_solver.sv
// Coefficient-serial key equation solver for binary BCH decoding.
// Assumes go is a one-cycle pulse with the syndrome stable, and that take
// is pulsed by the downstream stage once it has copied the result.
`timescale 1ns/1ps
`default_nettype none

module kes_solver (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             go,
    input  wire kes_pkg::kes_poly_t syndrome,
    input  wire logic             take,
    input  wire logic [3:0]       corr_count,
    input  wire logic             corr_count_valid,
    output logic                  result_pending_flag,
    output kes_pkg::kes_result_t  result,
    output logic                  uncorrectable
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_BRANCH, ST_UPDATE, ST_FULL} kes_state_t;

    kes_state_t         state;
    kes_pkg::kes_poly_t loc;
    kes_pkg::kes_poly_t aux_loc;
    kes_pkg::kes_poly_t val;
    kes_pkg::kes_poly_t aux_val;
    logic [3:0]         locator_degree;
    logic [3:0]         iter_j;
    logic [1:0]         grp_i;
    kes_pkg::kes_elem_t delta;
    kes_pkg::kes_elem_t gamma;
    logic               swap;
    logic [3:0]         taken_degree;

    // ************************************************************
    // decode
    // ************************************************************
    wire logic               start   = go && (state == ST_IDLE);
    wire kes_pkg::kes_elem_t disc    = val[iter_j[2:0]];
    wire logic               raise   = (disc != kes_pkg::ELEM_ZERO)
                                       && ({locator_degree, 1'b0} <= {1'b0, iter_j});
    wire logic [3:0]         next_j  = iter_j + kes_pkg::J_STEP;
    wire logic               last_it = (next_j == kes_pkg::J_LAST);
    wire logic [3:0]         next_deg = iter_j + 4'h1 - locator_degree;
    wire logic               grp_end = (grp_i == kes_pkg::GRP_BOTTOM);

    // shifted copies: in-place update from the top group down means lower
    // coefficients read here are still those of the previous iteration
    wire kes_pkg::kes_poly_t loc_x1  = {loc[kes_pkg::N2-2:0], kes_pkg::ELEM_ZERO};
    wire kes_pkg::kes_poly_t val_x1  = {val[kes_pkg::N2-2:0], kes_pkg::ELEM_ZERO};
    wire kes_pkg::kes_poly_t aloc_x1 = {aux_loc[kes_pkg::N2-2:0], kes_pkg::ELEM_ZERO};
    wire kes_pkg::kes_poly_t aval_x1 = {aux_val[kes_pkg::N2-2:0], kes_pkg::ELEM_ZERO};
    wire kes_pkg::kes_poly_t aloc_x2 = {aux_loc[kes_pkg::N2-3:0], {2{kes_pkg::ELEM_ZERO}}};
    wire kes_pkg::kes_poly_t aval_x2 = {aux_val[kes_pkg::N2-3:0], {2{kes_pkg::ELEM_ZERO}}};

    // ************************************************************
    // coefficient lanes
    // ************************************************************
    logic [2:0]         lane_idx  [kes_pkg::LANES];
    kes_pkg::kes_elem_t lane_loc  [kes_pkg::LANES];
    kes_pkg::kes_elem_t lane_aloc [kes_pkg::LANES];
    kes_pkg::kes_elem_t lane_val  [kes_pkg::LANES];
    kes_pkg::kes_elem_t lane_aval [kes_pkg::LANES];

    genvar ln;
    generate
        for (ln = 0; ln < kes_pkg::LANES; ln++) begin : g_lane
            assign lane_idx[ln]  = 3'(int'(grp_i) * kes_pkg::LANES + ln); // RULE_12
            // L' = gamma*L + delta*x*aL, same map on V keeps both key equations
            assign lane_loc[ln]  = kes_pkg::kes_gf_mul(gamma, loc[lane_idx[ln]])
                                 ^ kes_pkg::kes_gf_mul(delta, aloc_x1[lane_idx[ln]]); // RULE_02
            assign lane_val[ln]  = kes_pkg::kes_gf_mul(gamma, val[lane_idx[ln]])
                                 ^ kes_pkg::kes_gf_mul(delta, aval_x1[lane_idx[ln]]); // RULE_05
            // odd step has zero discrepancy, so aux gets one more shift per pass
            assign lane_aloc[ln] = swap ? loc_x1[lane_idx[ln]] : aloc_x2[lane_idx[ln]]; // RULE_06
            assign lane_aval[ln] = swap ? val_x1[lane_idx[ln]] : aval_x2[lane_idx[ln]];
        end
    endgenerate

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_BRANCH;
                    end
                end
                ST_BRANCH: begin
                    if (raise || disc != kes_pkg::ELEM_ZERO) begin
                        state <= ST_UPDATE;
                    end else if (last_it) begin
                        state <= ST_FULL; // RULE_10
                    end
                end
                ST_UPDATE: begin
                    if (grp_end) begin
                        state <= last_it ? ST_FULL : ST_BRANCH;
                    end
                end
                ST_FULL: begin
                    if (take) begin
                        state <= ST_IDLE; // RULE_11
                    end
                end
            endcase
        end
    end

    assign result_pending_flag = (state == ST_FULL);
    assign result              = '{loc: loc[kes_pkg::T_CAP:0], deg: locator_degree};

    // ************************************************************
    // branch section and indices
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            iter_j         <= kes_pkg::J_RESET;
            grp_i          <= kes_pkg::GRP_TOP;
            delta          <= kes_pkg::ELEM_ZERO;
            gamma          <= kes_pkg::ELEM_ONE;
            swap           <= 1'b0;
            locator_degree <= kes_pkg::DEG_RESET;
        end else if (start) begin
            iter_j         <= kes_pkg::J_RESET; // RULE_07
            grp_i          <= kes_pkg::GRP_TOP;
            gamma          <= kes_pkg::ELEM_ONE;
            locator_degree <= kes_pkg::DEG_RESET; // RULE_13
        end else if (state == ST_BRANCH) begin
            delta <= disc; // RULE_15
            swap  <= raise;
            grp_i <= kes_pkg::GRP_TOP;
            if (disc == kes_pkg::ELEM_ZERO && !last_it) begin
                iter_j <= next_j; // RULE_06
            end
        end else if (state == ST_UPDATE) begin
            grp_i <= grp_i - 2'h1; // RULE_09
            if (grp_end) begin
                iter_j <= last_it ? iter_j : next_j;
                if (swap) begin
                    gamma          <= delta;
                    locator_degree <= next_deg; // RULE_08
                end
            end
        end
    end

    // ************************************************************
    // polynomial registers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loc     <= '0;
            aux_loc <= '0;
            val     <= '0;
            aux_val <= '0;
        end else if (start) begin
            loc     <= kes_pkg::kes_poly_t'(kes_pkg::ELEM_ONE); // RULE_03
            aux_loc <= kes_pkg::kes_poly_t'(kes_pkg::ELEM_ONE); // RULE_04
            val     <= syndrome; // RULE_01
            aux_val <= syndrome;
        end else if (state == ST_BRANCH && disc == kes_pkg::ELEM_ZERO) begin
            aux_loc <= aloc_x2; // RULE_16
            aux_val <= aval_x2;
        end else if (state == ST_UPDATE) begin
            for (int k = 0; k < kes_pkg::LANES; k++) begin
                loc[lane_idx[k]]     <= lane_loc[k]; // RULE_17
                aux_loc[lane_idx[k]] <= lane_aloc[k];
                val[lane_idx[k]]     <= lane_val[k];
                aux_val[lane_idx[k]] <= lane_aval[k];
            end
        end
    end

    // ************************************************************
    // degree check against corrected count
    // ************************************************************
    // the degree is kept from take onward, since the solver may move on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            taken_degree  <= kes_pkg::DEG_RESET;
            uncorrectable <= 1'b0;
        end else begin
            if (state == ST_FULL && take) begin
                taken_degree <= locator_degree;
            end
            uncorrectable <= corr_count_valid && (corr_count != taken_degree); // RULE_14
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    load_syn_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        start |=> val == $past(syndrome))
        else $error("syndrome not loaded into V");
    init_loc_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
        start |=> loc == kes_pkg::kes_poly_t'(kes_pkg::ELEM_ONE) && locator_degree == 4'h0)
        else $error("locator not reset to one");
    aux_init_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        start |=> aux_loc == loc && aux_val == val)
        else $error("aux polynomials not equal to main");
    disc_pick_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        state == ST_BRANCH |=> delta == $past(val[iter_j[2:0]]))
        else $error("wrong discrepancy coefficient");
    zero_skip_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        state == ST_BRANCH && disc == 8'h00 |=> state != ST_UPDATE)
        else $error("zero discrepancy not skipped");
    deg_grow_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
        !start |=> locator_degree >= $past(locator_degree))
        else $error("locator degree fell");
    pend_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        result_pending_flag && !take |=> result_pending_flag && $stable(result))
        else $error("result not held while pending");
    pend_set_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        $rose(result_pending_flag) |-> iter_j == 4'h6 && !$past(start))
        else $error("pending raised before last iteration");
    branch_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_15
        state == ST_UPDATE && $past(state) == ST_UPDATE |-> $stable(delta) && $stable(swap))
        else $error("branch inputs changed mid iteration");
    update_len_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
        state == ST_BRANCH ##1 state == ST_UPDATE |-> state == ST_UPDATE [*4] ##1 state != ST_UPDATE)
        else $error("update pass length wrong");
    uncorr_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        corr_count_valid && corr_count != taken_degree |=> uncorrectable)
        else $error("mismatch not flagged");

endmodule : kes_solver

`default_nettype wire

// File: sim/kes_partner.sv
// Far-side model: syndrome source that issues go, and a downstream stage
// that takes each result after a programmable stall.
`timescale 1ns/1ps
`default_nettype none

module kes_partner (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              result_pending_flag,
    output var logic               go,
    output var kes_pkg::kes_poly_t syndrome,
    output var logic               take
);
    int   stall = 0;
    int   cnt   = 0;
    logic stray = 1'b0;

    initial begin
        go       = 1'b0;
        syndrome = '0;
        take     = 1'b0;
    end

    // one-cycle go; syndrome scrambled once taken so stale data shows
    task automatic send(input kes_pkg::kes_poly_t s);
        @(negedge clk);
        go       = 1'b1;
        syndrome = s;
        @(negedge clk);
        go       = 1'b0;
        syndrome = ~s;
    endtask : send

    // a take with nothing pending, only on command
    task automatic stray_take();
        @(posedge clk);
        stray = 1'b1;
        @(posedge clk);
        stray = 1'b0;
    endtask : stray_take

    // downstream busy for stall cycles, then one take per result
    always @(negedge clk) begin
        take <= stray || (rstn && result_pending_flag && !take && cnt >= stall);
        if (!rstn || !result_pending_flag || take) begin
            cnt <= 0;
        end else if (cnt >= stall) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : kes_partner

`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the key equation solver.
// Assumes the package field polynomial and t = 4; errors are placed by row.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct {int p[4]; int deg;} kes_tb_row_t;
    logic                 clk = 1'b0;
    logic                 rstn = 1'b0;
    logic                 go, take, pend, unc, cvalid;
    logic [3:0]           ccount;
    kes_pkg::kes_poly_t   syn;
    kes_pkg::kes_result_t res;
    int                   failures = 0;
    int                   num_checks = 0;
    int                   cycles = 0;
    int                   lats[6];
    int                   lat;
    kes_pkg::kes_result_t held;
    // deg errors sit at the first deg positions
    kes_tb_row_t rows[6] = '{'{'{0, 0, 0, 0}, 0}, '{'{5, 0, 0, 0}, 1},
        '{'{0, 7, 0, 0}, 2}, '{'{3, 100, 200, 0}, 3}, '{'{1, 50, 120, 254}, 4},
        '{'{9, 10, 0, 0}, 2}};

    always #4 clk = ~clk;

    kes_solver kes_solver_i (.clk(clk), .rstn(rstn), .go(go), .syndrome(syn), .take(take),
        .corr_count(ccount), .corr_count_valid(cvalid), .result_pending_flag(pend),
        .result(res), .uncorrectable(unc));
    kes_partner kes_partner_i (.clk(clk), .rstn(rstn), .result_pending_flag(pend),
        .go(go), .syndrome(syn), .take(take));

    // ************************************************************
    // field arithmetic, kept apart from the design's own
    // ************************************************************
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (b[k]) p ^= a;
            a = a[7] ? ((a << 1) ^ kes_pkg::GF_POLY) : (a << 1);
        end
        return p;
    endfunction : gmul

    function automatic logic [7:0] apow(input int e);
        logic [7:0] r;
        r = 8'h01;
        repeat (e % 255) r = gmul(r, 8'h02);
        return r;
    endfunction : apow

    function automatic kes_pkg::kes_poly_t syn_of(input kes_tb_row_t r);
        kes_pkg::kes_poly_t s;
        s = '0;
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < r.deg; i++) s[k] ^= apow((k + 1) * r.p[i]);
        end
        return s;
    endfunction : syn_of

    function automatic logic [7:0] eval(input kes_pkg::kes_result_t h, input logic [7:0] x);
        logic [7:0] acc;
        logic [7:0] xp;
        acc = 8'h00;
        xp  = 8'h01;
        for (int k = 0; k < 5; k++) begin
            acc ^= gmul(h.loc[k], xp);
            xp  = gmul(xp, x);
        end
        return acc;
    endfunction : eval

    // ************************************************************
    // checking tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
            failures++;
        end
    endtask : chk

    task automatic conclude();
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic wait_pend(output int n);
        n = 0;
        while (pend !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("pending", 1, pend);
    endtask : wait_pend

    task automatic cnt_chk(input int c, input logic e);
        @(negedge clk);
        ccount = 4'(c);
        cvalid = 1'b1;
        @(negedge clk);
        cvalid = 1'b0;
        chk("uncorrectable", e, unc);
        @(negedge clk);
        chk("uncorrectable pulse", 0, unc);
    endtask : cnt_chk

    task automatic run_row(input kes_tb_row_t r, output int n);
        kes_pkg::kes_result_t h;
        kes_partner_i.stall = 3;
        kes_partner_i.send(syn_of(r));
        wait_pend(n);
        h = res;
        chk("latency", 1, n >= 4 && n <= 20);
        chk("degree", r.deg, h.deg);
        chk("locator constant", 1, h.loc[0] != 8'h00);
        for (int k = r.deg + 1; k < 5; k++) chk("high coeff", 0, h.loc[k]);
        for (int i = 0; i < r.deg; i++) chk("root", 0, eval(h, apow(255 - r.p[i])));
        repeat (2) @(negedge clk);
        chk("pending held", 1, pend);
        chk("result held", h, res);
        repeat (3) @(negedge clk);
        chk("pending cleared", 0, pend);
        cnt_chk(r.deg, 1'b0);
        cnt_chk(r.deg + 1, 1'b1);
    endtask : run_row

    // ************************************************************
    // main sequence
    // ************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        ccount = 4'h0;
        cvalid = 1'b0;
        repeat (6) @(negedge clk);
        chk("reset state", 0, {pend, unc, res});
        rstn = 1'b1;
        foreach (rows[i]) run_row(rows[i], lats[i]);
        chk("latency grows", 1, lats[4] > lats[0]);
        // go while pending must not disturb the held result
        kes_partner_i.stall = 1000;
        kes_partner_i.send(syn_of(rows[2]));
        wait_pend(lat);
        held = res;
        kes_partner_i.send(syn_of(rows[4]));
        repeat (25) @(negedge clk);
        chk("ignored go", held, res);
        kes_partner_i.stall = 0;
        repeat (3) @(negedge clk);
        chk("pending cleared", 0, pend);
        // stray take while computing is ignored
        kes_partner_i.stall = 1000;
        kes_partner_i.send(syn_of(rows[3]));
        kes_partner_i.stray_take();
        wait_pend(lat);
        chk("degree", 3, res.deg);
        kes_partner_i.stall = 0;
        repeat (3) @(negedge clk);
        // reset in mid computation, then a clean codeword
        kes_partner_i.send(syn_of(rows[4]));
        repeat (3) @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        chk("mid reset", 0, {pend, unc, res});
        rstn = 1'b1;
        run_row(rows[0], lat);
        conclude();
    end
endmodule : tb_top

`default_nettype wire
